// ### common/spicc_params.svh
// Offsets, field positions and reset values of the serial port block
`ifndef SPICC_PARAMS_SVH
`define SPICC_PARAMS_SVH
`define SPICC_OFF_CTRL1 8'h00
`define SPICC_OFF_CTRL2 8'h04
`define SPICC_OFF_STS 8'h08
`define SPICC_OFF_DATA 8'h0C
`define SPICC_C1_CLOCK_PHASE 0
`define SPICC_C1_CPOL 1
`define SPICC_C1_MSTR 2
`define SPICC_C1_BR_LO 3
`define SPICC_C1_BR_HI 5
`define SPICC_C1_EN 6
`define SPICC_C1_LSB 7
`define SPICC_C1_ISEL 8
`define SPICC_C1_SWSEL 9
`define SPICC_C1_RXONLY 10
`define SPICC_C1_CRC_CHECK_ENABLE 13
`define SPICC_C1_BIDIROE 14
`define SPICC_C1_BIDIR 15
`define SPICC_C2_RXDMA 0
`define SPICC_C2_TXDMA 1
`define SPICC_C2_SSOE 2
`define SPICC_C2_PULSE 3
`define SPICC_C2_FRF 4
`define SPICC_C2_ERRIE 5
`define SPICC_C2_RXIE 6
`define SPICC_C2_TXIE 7
`define SPICC_C2_DS_LO 8
`define SPICC_C2_DS_HI 11
`define SPICC_C2_FRT 12
`define SPICC_C2_RX_DMA_COUNT_ODD 13
`define SPICC_C2_TX_DMA_COUNT_ODD 14
`define SPICC_ST_RXNE 0
`define SPICC_ST_TXE 1
`define SPICC_ST_OVR 6
`define SPICC_ST_BSY 7
`define SPICC_C1_RST 16'h0000
`define SPICC_C2_RST 16'h0700
`define SPICC_C1_LOCK 16'h2000
`define SPICC_C2_LOCK 16'h6018
`define SPICC_C2_WMASK 16'h7FFF
`define SPICC_DS_MIN 4'h3
`define SPICC_DS_DEFAULT 4'h7
`define SPICC_PACK_MAX 5'h08
`define SPICC_PIN_IDLE 4'h2
`endif

// ### common/spicc_pkg.sv
// Types shared by the serial port block
package spicc_pkg;
    typedef enum {MS_IDLE, MS_SETUP, MS_RUN, MS_GAP} spicc_mstate_e;
    typedef logic [4:0] spicc_width_t;
    typedef logic [15:0] spicc_word_t;
endpackage : spicc_pkg

// ### common/spicc_eng_if.sv
// Link between the port control logic and its shift engine
`timescale 1ns/100ps
interface spicc_eng_if;
    logic load;
    logic abort;
    logic sampleEdge;
    logic shiftEdge;
    logic lsbFirst;
    logic inBit;
    spicc_pkg::spicc_width_t width;
    spicc_pkg::spicc_word_t txWord;
    logic outBit;
    logic done;
    logic busy;
    spicc_pkg::spicc_word_t rxWord;
    modport ctl (output load, abort, sampleEdge, shiftEdge, lsbFirst,
        inBit, width, txWord, input outBit, done, busy, rxWord);
    modport eng (input load, abort, sampleEdge, shiftEdge, lsbFirst,
        inBit, width, txWord, output outBit, done, busy, rxWord);
endinterface : spicc_eng_if

// ### verilog/spicc_shift.sv
// Frame shift engine: serialises one word and collects one word
`timescale 1ns/100ps
module spicc_shift (
    input wire logic clk, // Bus clock
    input wire logic rstn, // Sync reset, active low
    spicc_eng_if.eng e // Engine side of the link
);
    spicc_pkg::spicc_word_t txSh_q;
    spicc_pkg::spicc_word_t rxSh_q;
    spicc_pkg::spicc_word_t rxWord_q;
    logic [4:0] cnt_q;
    logic busy_q;
    logic done_q;
    logic [3:0] msbIdx;
    logic [4:0] padBits;
    logic lastBit;
    logic doSample;
    logic doShift;
    spicc_pkg::spicc_word_t rxNext;

    // Bit selection and edge qualification
    assign msbIdx = 4'(e.width - 5'd1);
    assign padBits = 5'(5'd16 - e.width);
    assign lastBit = cnt_q == 5'(e.width - 5'd1);
    assign doSample = e.sampleEdge & busy_q;
    // No shift before the first sample, so phase 1 keeps bit one
    assign doShift = e.shiftEdge & busy_q & (cnt_q != 5'd0);
    assign rxNext = e.lsbFirst ? {e.inBit, rxSh_q[15:1]}
                               : {rxSh_q[14:0], e.inBit};
    assign e.outBit = e.lsbFirst ? txSh_q[0] : txSh_q[msbIdx];
    assign e.busy = busy_q;
    assign e.done = done_q;
    assign e.rxWord = rxWord_q;

    // Shift registers and bit count; load wins over edges
    always_ff @(posedge clk) begin
        if (!rstn) begin
            txSh_q <= 16'h0000;
            rxSh_q <= 16'h0000;
            cnt_q <= 5'h00;
            busy_q <= 1'b0;
        end else if (e.abort) begin
            busy_q <= 1'b0;
        end else if (e.load) begin
            txSh_q <= e.txWord;
            rxSh_q <= 16'h0000;
            cnt_q <= 5'h00;
            busy_q <= 1'b1;
        end else begin
            if (doShift) begin
                txSh_q <= e.lsbFirst ? txSh_q >> 1 : txSh_q << 1;
            end
            if (doSample) begin
                rxSh_q <= rxNext;
                cnt_q <= 5'(cnt_q + 5'd1);
                busy_q <= ~lastBit;
            end
        end
    end

    // Completed word, right aligned, with a one-cycle done pulse
    always_ff @(posedge clk) begin
        if (!rstn) begin
            done_q <= 1'b0;
            rxWord_q <= 16'h0000;
        end else begin
            done_q <= doSample & lastBit & ~e.abort & ~e.load;
            if (doSample & lastBit) begin
                rxWord_q <= e.lsbFirst ? rxNext >> padBits : rxNext;
            end
        end
    end
endmodule : spicc_shift

// ### verilog/spicc_top.sv
// Serial port control registers, link timing and pin steering
`timescale 1ns/100ps
`include "spicc_params.svh"
// Contract
// - CRC only full duplex, locked while enabled
// - Bidir output enable picks line direction
// - Bidir mode bit selects single shared line
// - Receive DMA request while receive not empty
// - Transmit DMA request while transmit empty
// - Select output enable drives select pin
// - Pulse select high between continuous frames
// - Single frame end forces select high in pulse mode
// - Pulse ignored for phase one, alternative
// - Frame format bit, locked while enabled
// - Error interrupt gated by its enable
// - Receive interrupt while receive not empty
// - Transmit interrupt while transmit empty
// - Width field: code plus one bits
// - Reserved width codes stored as eight
// - Threshold bit: sixteen or eight bits
// - Receive odd count bit, locked while enabled
// - Transmit odd count bit, locked while enabled
// - Second control word resets to 0x0700
// - Status shows receive full, transmit empty
// - Half word and word accesses accepted
module spicc_top (
    input wire logic clk, // Bus clock, 40 MHz
    input wire logic rstn, // Sync reset, active low
    input wire logic [7:0] regAddr, // Register byte address
    input wire logic [31:0] regWdata, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    output logic [31:0] regRdata, // Read data, cycle after strobe
    input wire logic sckIn, // Link clock pin level
    output logic sckOut, // Link clock drive
    output logic sckOe, // Link clock drive enable
    input wire logic nssIn, // Select pin level
    output logic nssOut, // Select drive
    output logic nssOe, // Select drive enable
    input wire logic mosiIn, // Master-out line level
    output logic mosiOut, // Master-out drive
    output logic mosiOe, // Master-out drive enable
    input wire logic misoIn, // Master-in line level
    output logic misoOut, // Master-in drive
    output logic misoOe, // Master-in drive enable
    output logic rxDmaReq, // Receive DMA request
    output logic txDmaReq, // Transmit DMA request
    output logic irqReq, // Interrupt request
    output logic crcActive, // CRC unit may check
    output logic rxDmaCountOdd, // Receive count odd, packing
    output logic txDmaCountOdd // Transmit count odd, packing
);
    spicc_eng_if eng ();

    spicc_shift uShift (
        .clk(clk),
        .rstn(rstn),
        .e(eng.eng)
    );

    // Pin synchronisers: three stages, change taken when 2nd and 3rd agree
    logic [3:0] pinRaw;
    logic [3:0] pinF;
    assign pinRaw = {misoIn, mosiIn, nssIn, sckIn};
    for (genvar i = 0; i < 4; i++) begin : gSync
        logic a_q;
        logic b_q;
        logic c_q;
        logic f_q;
        localparam logic [3:0] Idle = `SPICC_PIN_IDLE;
        always_ff @(posedge clk) begin
            if (!rstn) begin
                a_q <= Idle[i];
                b_q <= Idle[i];
                c_q <= Idle[i];
                f_q <= Idle[i];
            end else begin
                a_q <= pinRaw[i];
                b_q <= a_q;
                c_q <= b_q;
                if (b_q == c_q) begin
                    f_q <= c_q;
                end
            end
        end
        assign pinF[i] = f_q;
    end
    logic sckF;
    logic nssF;
    logic mosiF;
    logic misoF;
    assign sckF = pinF[0];
    assign nssF = pinF[1];
    assign mosiF = pinF[2];
    assign misoF = pinF[3];

    // Control words and their fields
    logic [15:0] ctrl1_q;
    logic [15:0] ctrl2_q;
    logic clock_phase, cpol, master, portEn, lsbFirst, rxOnly;
    logic bidir, bidirOe, crc_check_enable, swSel, intSel;
    logic [2:0] baud;
    logic rxDmaEn, txDmaEn, selOutEn, pulseEn, altFrame;
    logic errIe, rxIe, txIe, rxThr8;
    logic [3:0] dsCode;
    spicc_pkg::spicc_width_t width;
    assign clock_phase = ctrl1_q[`SPICC_C1_CLOCK_PHASE];
    assign cpol = ctrl1_q[`SPICC_C1_CPOL];
    assign master = ctrl1_q[`SPICC_C1_MSTR];
    assign baud = ctrl1_q[`SPICC_C1_BR_HI:`SPICC_C1_BR_LO];
    assign portEn = ctrl1_q[`SPICC_C1_EN];
    assign lsbFirst = ctrl1_q[`SPICC_C1_LSB];
    assign intSel = ctrl1_q[`SPICC_C1_ISEL];
    assign swSel = ctrl1_q[`SPICC_C1_SWSEL];
    assign rxOnly = ctrl1_q[`SPICC_C1_RXONLY];
    assign crc_check_enable = ctrl1_q[`SPICC_C1_CRC_CHECK_ENABLE];
    assign bidirOe = ctrl1_q[`SPICC_C1_BIDIROE];
    assign bidir = ctrl1_q[`SPICC_C1_BIDIR];
    assign rxDmaEn = ctrl2_q[`SPICC_C2_RXDMA];
    assign txDmaEn = ctrl2_q[`SPICC_C2_TXDMA];
    assign selOutEn = ctrl2_q[`SPICC_C2_SSOE];
    assign pulseEn = ctrl2_q[`SPICC_C2_PULSE];
    assign altFrame = ctrl2_q[`SPICC_C2_FRF];
    assign errIe = ctrl2_q[`SPICC_C2_ERRIE];
    assign rxIe = ctrl2_q[`SPICC_C2_RXIE];
    assign txIe = ctrl2_q[`SPICC_C2_TXIE];
    assign dsCode = ctrl2_q[`SPICC_C2_DS_HI:`SPICC_C2_DS_LO];
    assign width = 5'({1'b0, dsCode} + 5'd1);
    assign rxThr8 = ctrl2_q[`SPICC_C2_FRT];
    assign rxDmaCountOdd = ctrl2_q[`SPICC_C2_RX_DMA_COUNT_ODD];
    assign txDmaCountOdd = ctrl2_q[`SPICC_C2_TX_DMA_COUNT_ODD];

    // Address decode; upper half of a word write is ignored
    logic selC1, selC2, selSts, selData;
    logic wrC1, wrC2, wrSts, wrData, rdData;
    assign selC1 = regAddr == `SPICC_OFF_CTRL1;
    assign selC2 = regAddr == `SPICC_OFF_CTRL2;
    assign selSts = regAddr == `SPICC_OFF_STS;
    assign selData = regAddr == `SPICC_OFF_DATA;
    assign wrC1 = regWr & selC1;
    assign wrC2 = regWr & selC2;
    assign wrSts = regWr & selSts;
    assign wrData = regWr & selData;
    assign rdData = regRd & selData;

    // Locked bits keep their value while the port is enabled
    logic [15:0] lock1, lock2, c1Next, c2Raw, c2Next;
    logic [3:0] dsIn, dsFix;
    assign lock1 = portEn ? `SPICC_C1_LOCK : 16'h0000;
    assign lock2 = portEn ? `SPICC_C2_LOCK : 16'h0000;
    assign c1Next = (regWdata[15:0] & ~lock1) | (ctrl1_q & lock1);
    assign c2Raw = ((regWdata[15:0] & ~lock2) | (ctrl2_q & lock2))
        & `SPICC_C2_WMASK;
    assign dsIn = c2Raw[`SPICC_C2_DS_HI:`SPICC_C2_DS_LO];
    assign dsFix = (dsIn < `SPICC_DS_MIN) ? `SPICC_DS_DEFAULT : dsIn;
    assign c2Next = {c2Raw[15:`SPICC_C2_DS_HI + 1], dsFix,
        c2Raw[`SPICC_C2_DS_LO - 1:0]};

    // Control word storage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl1_q <= `SPICC_C1_RST;
            ctrl2_q <= `SPICC_C2_RST;
        end else begin
            if (wrC1) begin
                ctrl1_q <= c1Next;
            end
            if (wrC2) begin
                ctrl2_q <= c2Next;
            end
        end
    end

    // Master link timing: half period is 2^baud bus clocks
    spicc_pkg::spicc_mstate_e mst_q;
    logic [7:0] halfCnt_q;
    logic [5:0] edgeCnt_q;
    logic sck_q;
    logic [7:0] halfLast;
    logic tick, mRun, mLoad, frameEnd, stepIdle;
    logic txFull_q;
    logic pulseMode;
    assign halfLast = 8'((8'h01 << baud) - 8'h01);
    assign tick = halfCnt_q == halfLast;
    assign mRun = mst_q == spicc_pkg::MS_RUN;
    assign stepIdle = ~portEn | ~master;
    // Pulse handling is off for phase one and the alternative format
    assign pulseMode = pulseEn & ~clock_phase & ~altFrame;
    assign frameEnd = mRun & tick
        & (edgeCnt_q == 6'({width, 1'b0} - 6'd1));
    assign mLoad = ~stepIdle & txFull_q
        & ((mst_q == spicc_pkg::MS_IDLE)
        | ((mst_q == spicc_pkg::MS_GAP) & tick));

    // Master state; a gap of one half period separates frames
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mst_q <= spicc_pkg::MS_IDLE;
        end else if (stepIdle) begin
            mst_q <= spicc_pkg::MS_IDLE;
        end else begin
            unique case (mst_q)
                spicc_pkg::MS_IDLE: begin
                    if (mLoad) begin
                        mst_q <= spicc_pkg::MS_SETUP;
                    end
                end
                spicc_pkg::MS_SETUP: begin
                    if (tick) begin
                        mst_q <= spicc_pkg::MS_RUN;
                    end
                end
                spicc_pkg::MS_RUN: begin
                    if (frameEnd) begin
                        mst_q <= spicc_pkg::MS_GAP;
                    end
                end
                spicc_pkg::MS_GAP: begin
                    if (tick) begin
                        mst_q <= mLoad ? spicc_pkg::MS_SETUP
                                       : spicc_pkg::MS_IDLE;
                    end
                end
            endcase
        end
    end

    // Half period counter, edge counter and clock level
    always_ff @(posedge clk) begin
        if (!rstn) begin
            halfCnt_q <= 8'h00;
            edgeCnt_q <= 6'h00;
            sck_q <= 1'b0;
        end else begin
            halfCnt_q <= (tick | (mst_q == spicc_pkg::MS_IDLE))
                ? 8'h00 : 8'(halfCnt_q + 8'h01);
            if (!mRun) begin
                edgeCnt_q <= 6'h00;
                sck_q <= cpol;
            end else if (tick) begin
                edgeCnt_q <= 6'(edgeCnt_q + 6'h01);
                sck_q <= ~sck_q;
            end
        end
    end

    // Slave side: select and edges of the sampled link clock
    logic sckPrev_q;
    logic slvSel, sckEdge, lead, trail;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sckPrev_q <= 1'b0;
        end else begin
            sckPrev_q <= sckF;
        end
    end
    assign slvSel = portEn & ~master & (swSel ? ~intSel : ~nssF);
    assign sckEdge = master ? (mRun & tick) : (slvSel & (sckF ^ sckPrev_q));
    // Leading edge moves the clock away from its idle level
    assign lead = sckEdge & (master ? (sck_q == cpol) : (sckF != cpol));
    assign trail = sckEdge & ~lead;

    // Engine steering
    logic sLoad;
    assign sLoad = slvSel & ~eng.busy;
    assign eng.load = master ? mLoad : sLoad;
    assign eng.abort = ~portEn | (~master & ~slvSel);
    assign eng.sampleEdge = clock_phase ? trail : lead;
    assign eng.shiftEdge = clock_phase ? lead : trail;
    assign eng.lsbFirst = lsbFirst;
    assign eng.width = width;

    // Transmit buffer; underrun in slave mode sends zeros
    logic [15:0] txBuf_q;
    assign eng.txWord = txFull_q ? txBuf_q : 16'h0000;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            txBuf_q <= 16'h0000;
            txFull_q <= 1'b0;
        end else begin
            if (wrData) begin
                txBuf_q <= regWdata[15:0];
            end
            // A write in the taking cycle keeps the buffer full
            txFull_q <= wrData | (txFull_q & ~eng.load);
        end
    end

    // Receive buffer with byte packing below the sixteen-bit threshold
    logic [15:0] rxBuf_q;
    logic rxNe_q;
    logic rxHalf_q;
    logic ovr_q;
    logic packLow, rxDone, rxFull, rxLost;
    assign packLow = (width <= `SPICC_PACK_MAX) & ~rxThr8;
    assign rxDone = eng.done & ~(packLow & ~rxHalf_q);
    assign rxFull = rxNe_q & ~rdData;
    assign rxLost = rxDone & rxFull;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rxBuf_q <= 16'h0000;
            rxHalf_q <= 1'b0;
        end else if (eng.done & packLow & ~rxHalf_q) begin
            rxBuf_q[7:0] <= eng.rxWord[7:0];
            rxHalf_q <= 1'b1;
        end else if (rxDone & ~rxFull) begin
            rxBuf_q <= packLow ? {eng.rxWord[7:0], rxBuf_q[7:0]}
                               : eng.rxWord;
            rxHalf_q <= 1'b0;
        end
    end

    // Flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rxNe_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            rxNe_q <= (rxDone & ~rxFull) | rxFull;
            ovr_q <= rxLost
                | (ovr_q & ~(wrSts & ~regWdata[`SPICC_ST_OVR]));
        end
    end

    // Status word and read data, valid only the cycle after a read
    logic busy;
    logic [15:0] stsWord;
    logic [31:0] rdMux;
    logic [31:0] rdata_q;
    assign busy = eng.busy | (mst_q != spicc_pkg::MS_IDLE);
    assign stsWord = (16'(rxNe_q) << `SPICC_ST_RXNE)
        | (16'(!txFull_q) << `SPICC_ST_TXE)
        | (16'(ovr_q) << `SPICC_ST_OVR)
        | (16'(busy) << `SPICC_ST_BSY);
    assign rdMux = selC1 ? {16'h0000, ctrl1_q}
        : selC2 ? {16'h0000, ctrl2_q}
        : selSts ? {16'h0000, stsWord}
        : selData ? {16'h0000, rxBuf_q} : 32'h0000_0000;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= regRd ? rdMux : 32'h0000_0000;
        end
    end
    assign regRdata = rdata_q;

    // Requests to DMA and interrupt controller
    assign rxDmaReq = rxDmaEn & rxNe_q;
    assign txDmaReq = txDmaEn & ~txFull_q;
    assign irqReq = (errIe & ovr_q)
        | (rxIe & rxNe_q)
        | (txIe & ~txFull_q);
    assign crcActive = crc_check_enable & ~bidir & ~rxOnly;

    // Data line steering; receive direction releases the line
    logic drive;
    assign drive = bidir ? bidirOe : ~rxOnly;
    assign mosiOe = portEn & master & drive;
    assign misoOe = slvSel & drive;
    assign mosiOut = eng.outBit;
    assign misoOut = eng.outBit;
    assign eng.inBit = master ? (bidir ? mosiF : misoF)
                              : (bidir ? misoF : mosiF);

    // Clock and select drive; select low spans frame in pulse mode
    logic nssHigh;
    assign sckOe = portEn & master;
    assign sckOut = sck_q;
    assign nssHigh = altFrame ? (mst_q == spicc_pkg::MS_SETUP)
        : pulseMode ? ((mst_q == spicc_pkg::MS_IDLE)
        | (mst_q == spicc_pkg::MS_GAP))
        : ~portEn;
    assign nssOut = nssHigh;
    assign nssOe = portEn & master & (selOutEn | altFrame);
endmodule : spicc_top

// ### verif/spicc_monitor.sv
// Property checker for the serial port control block
`timescale 1ns/100ps
module spicc_monitor (
    input wire logic clk, // Bus clock
    input wire logic rstn, // Reset, active low
    input wire logic [7:0] regAddr, // Address
    input wire logic [31:0] regWdata, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    input wire logic [31:0] regRdata, // Read data
    input wire logic nssOe, // Select enable
    input wire logic mosiOe, // Out line enable
    input wire logic misoOe, // In line enable
    input wire logic rxDmaReq, // Rx request
    input wire logic txDmaReq, // Tx request
    input wire logic irqReq, // Interrupt
    input wire logic crcActive // CRC on
);
    logic [15:0] c1Q;
    logic [15:0] c2Q;
    wire [15:0] lk1 = c1Q[6] ? 16'h2000 : 16'h0000;
    wire [15:0] lk2 = c1Q[6] ? 16'h6018 : 16'h0000;
    // Shadow words; locked bits keep old value while enabled
    always_ff @(posedge clk) begin
        if (!rstn) begin
            c1Q <= 16'h0000;
            c2Q <= 16'h0700;
        end else if (regWr && regAddr == 8'h04) begin
            c2Q <= (regWdata[15:0] & ~lk2) | (c2Q & lk2);
        end else if (regWr && regAddr == 8'h00) begin
            c1Q <= (regWdata[15:0] & ~lk1) | (c1Q & lk1);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_dsLegal;
        regRd && regAddr == 8'h04 |=> regRdata[11:8] >= 4'h3;
    endproperty
    a_dsLegal: assert property (p_dsLegal)
        else $error("width code reserved");
    property p_lock;
        regRd && regAddr == 8'h04 |=> regRdata[14:12] == $past(c2Q[14:12])
            && regRdata[7:0] == $past(c2Q[7:0]);
    endproperty
    a_lock: assert property (p_lock)
        else $error("second word differs from writes");
    property p_rxDma;
        rxDmaReq |-> c2Q[0];
    endproperty
    a_rxDma: assert property (p_rxDma) else $error("rx request");
    property p_txDma;
        $rose(txDmaReq) |-> c2Q[1];
    endproperty
    a_txDma: assert property (p_txDma) else $error("tx request");
    property p_irq;
        irqReq |-> |c2Q[7:5];
    endproperty
    a_irq: assert property (p_irq) else $error("irq not enabled");
    property p_release;
        c1Q[15] && !c1Q[14] |-> !mosiOe && !misoOe;
    endproperty
    a_release: assert property (p_release) else $error("line held");
    property p_drvDir;
        mosiOe |-> !c1Q[15] || c1Q[14];
    endproperty
    a_drvDir: assert property (p_drvDir) else $error("drive dir");
    property p_crc;
        crcActive |-> c1Q[13] && !c1Q[15];
    endproperty
    a_crc: assert property (p_crc) else $error("crc outside duplex");
    property p_nssOe;
        !c2Q[2] && !c2Q[4] |-> !nssOe;
    endproperty
    a_nssOe: assert property (p_nssOe) else $error("select driven");
    c_rxDma: cover property (rxDmaReq);
    c_txDma: cover property (txDmaReq);
    c_irq: cover property (irqReq);
endmodule : spicc_monitor

bind spicc_top spicc_monitor mon (.clk, .rstn, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .nssOe, .mosiOe, .misoOe, .rxDmaReq,
    .txDmaReq, .irqReq, .crcActive);

// ### verif/spicc_slave_model.sv
// Far-side serial slave: one word per frame out, bits in
`timescale 1ns/100ps
module spicc_slave_model (
    input wire logic sck, // Link clock, idle low
    input wire logic nss, // Select, active low
    input wire logic mosi, // Data from master
    output logic miso, // Data to master
    input wire logic [15:0] txWord, // Base word, top aligned
    output logic [15:0] rxWord, // Collected bits
    output int frames // Whole frames seen
);
    logic [15:0] sh;
    int bitCnt;
    initial begin
        sh = 16'h0000;
        rxWord = 16'h0000;
        frames = 0;
        bitCnt = 0;
    end
    // Released line shows the inverse, so a stale bit never passes
    assign miso = nss ? ~sh[15] : sh[15];
    // Each frame sends base word plus frame count
    always @(negedge nss) begin
        sh = txWord + {frames[7:0], 8'h00};
        bitCnt = 0;
    end
    // Sample on rising edges, eight bits make a frame
    always @(posedge sck) begin
        if (!nss) begin
            rxWord = {rxWord[14:0], mosi};
            bitCnt = bitCnt + 1;
            if (bitCnt == 8) begin
                frames = frames + 1;
            end
        end
    end
    // Next bit on falling edges; reload after a whole frame
    always @(negedge sck) begin
        if (bitCnt == 8) begin
            sh = txWord + {frames[7:0], 8'h00};
            bitCnt = 0;
        end else begin
            sh = {sh[14:0], 1'b0};
        end
    end
endmodule : spicc_slave_model

// ### verif/tb_spi_control_config.sv
// Self-checking bench for the serial port control block
`timescale 1ns/100ps
module tb_spi_control_config;
    logic clk, rstn, regWr, regRd, noise, rdLate;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata;
    logic sckOut, sckOe, nssOut, nssOe, mosiOut, mosiOe, misoOut, misoOe;
    logic rxDmaReq, txDmaReq, irqReq, crcActive, slvMiso;
    logic rxDmaCountOdd, txDmaCountOdd;
    logic [15:0] rnd, slvTx, slvRx;
    logic [31:0] expQ[$];
    int fails, checked, cyc, slvFrames, nssRise;
    // Pin levels from the block's drive enables; link clock parks low
    wire sckIn = sckOe ? sckOut : 1'b0;
    wire nssIn = nssOe ? nssOut : 1'b1;
    wire mosiIn = mosiOe ? mosiOut : noise;
    wire misoIn = misoOe ? misoOut : slvMiso;
    spicc_top uut (.clk, .rstn, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .sckIn, .sckOut, .sckOe, .nssIn, .nssOut, .nssOe,
        .mosiIn, .mosiOut, .mosiOe, .misoIn, .misoOut, .misoOe,
        .rxDmaReq, .txDmaReq, .irqReq, .crcActive, .rxDmaCountOdd,
        .txDmaCountOdd);
    spicc_slave_model slv (.sck(sckIn), .nss(nssIn), .mosi(mosiIn),
        .miso(slvMiso), .txWord(slvTx), .rxWord(slvRx), .frames(slvFrames));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [15:0] xs(input logic [15:0] s);
        logic [15:0] t;
        t = s ^ (s << 7);
        t = t ^ (t >> 9);
        return t ^ (t << 8);
    endfunction : xs
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic conclude();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    // Random upper half rides along: only the low half counts
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        rnd = xs(rnd);
        regAddr <= a;
        regWdata <= {rnd, d};
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        expQ.push_back(e);
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
    endtask : rd
    task automatic waitHi(ref logic s);
        repeat (400) begin
            if (s === 1'b1) break;
            @(posedge clk);
        end
    endtask : waitHi
    // Read data stand one cycle after the strobe: compare mid cycle
    always @(negedge clk) begin
        if (rdLate) begin
            chk(regRdata, expQ.pop_front());
        end
        rdLate = regRd;
    end
    // Hang guard, select pulse count and line noise
    always @(posedge clk) begin
        cyc <= cyc + 1;
        noise <= ~noise;
        if (cyc == 5000) begin
            fails++;
            conclude();
        end
    end
    always @(posedge nssOut) nssRise++;
    initial begin
        {regAddr, regWdata, regWr, regRd, rstn, noise, rdLate} = '0;
        {fails, checked, cyc, nssRise} = '0;
        rnd = 16'h2CFC;
        slvTx = 16'h3C00;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(8'h04, 32'h0000_0700);
        rd(8'h00, 32'h0000_0000);
        rd(8'h08, 32'h0000_0002);
        // Every width code; reserved ones fall back to eight bits
        for (int i = 0; i < 16; i++) begin
            wr(8'h04, 16'(i << 8));
            rd(8'h04, i < 3 ? 32'h0000_0700 : 32'(i << 8));
        end
        wr(8'h04, 16'h0782);
        chk({txDmaReq, irqReq, rxDmaReq}, 32'h6);
        wr(8'h04, 16'h0700);
        chk({txDmaReq, irqReq}, 32'h0);
        // Locked bits ignored while enabled; bidir output enable picks drive
        wr(8'h00, 16'h0054);
        wr(8'h04, 16'h6718);
        rd(8'h04, 32'h0000_0700);
        chk({rxDmaCountOdd, txDmaCountOdd, nssOe}, 32'h0);
        wr(8'h00, 16'h2054);
        rd(8'h00, 32'h0000_0054);
        wr(8'h00, 16'h8054);
        chk({mosiOe, misoOe}, 32'h0);
        wr(8'h00, 16'hC054);
        chk(mosiOe, 32'h1);
        // Single frame, pulse mode, eight bit threshold
        // Half period of eight clocks outlasts the pin synchroniser delay
        wr(8'h00, 16'h001C);
        wr(8'h04, 16'h176D);
        wr(8'h00, 16'h005C);
        chk(nssOe, 32'h1);
        wr(8'h0C, 16'h00A5);
        waitHi(rxDmaReq);
        repeat (12) @(posedge clk);
        chk({rxDmaReq, irqReq, nssOut}, 32'h7);
        chk(slvRx[7:0], 32'h00A5);
        rd(8'h0C, 32'h0000_003C);
        chk({rxDmaReq, irqReq}, 32'h0);
        // Two continuous frames packed into one word
        slvTx <= 16'h5A00;
        nssRise = 0;
        wr(8'h04, 16'h076F);
        wr(8'h0C, 16'h0011);
        waitHi(txDmaReq);
        wr(8'h0C, 16'h0022);
        waitHi(rxDmaReq);
        repeat (12) @(posedge clk);
        chk(nssRise, 32'h2);
        chk(slvRx, 32'h1122);
        rd(8'h0C, 32'h0000_5C5B);
        // CRC only in full duplex
        wr(8'h00, 16'h0000);
        wr(8'h00, 16'h2000);
        chk(crcActive, 32'h1);
        wr(8'h00, 16'hA000);
        chk(crcActive, 32'h0);
        conclude();
    end
endmodule : tb_spi_control_config
